// *** feioc_top.v ***
// serial flash command interpreter: chip erase, id reads, otp registers
`timescale 1ns/100ps
`include "feioc_defines.vh"
module feioc_top #(
  parameter [31:0]  ARRAY_ERASE_CYCLES = `FEIOC_ARRAY_ERASE_CYCLES,
  parameter [31:0]  SMALL_ERASE_CYCLES = `FEIOC_SMALL_ERASE_CYCLES,
  parameter [7:0]   MAKER_CODE         = 8'h5a,   // arbitrary value
  parameter [7:0]   DEVICE_CODE        = 8'h14,   // arbitrary value
  parameter [7:0]   MEM_TYPE_CODE      = 8'h63,   // arbitrary value
  parameter [7:0]   CAPACITY_CODE      = 8'h15,   // arbitrary value
  parameter [127:0] UNIQUE_ID          = 128'h0123456789abcdef_fedcba9876543210 // arbitrary
) (
  input  wire clock,
  input  wire rst_n,
  input  wire spi_cs_n,            // select pin, async
  input  wire spi_sclk,            // serial clock pin, async
  input  wire spi_si,              // serial data in pin, async
  output reg  spi_so,              // serial data out
  output reg  spi_so_oe,           // high while driving spi_so
  input  wire protect_bit_2,
  input  wire protect_bit_1,
  input  wire protect_bit_0,
  input  wire protect_complement,
  input  wire otp_lock_1,
  input  wire otp_lock_2,
  input  wire otp_lock_3,
  output reg  latch_enabled_flag,
  output reg  in_progress_bit
);

  // ----------------------------------------------------------------------
  // frame phases and cycle kinds
  // ----------------------------------------------------------------------
  localparam [2:0] PH_CMD   = 3'h0;   // shifting opcode
  localparam [2:0] PH_ADDR  = 3'h1;   // shifting 24 address bits
  localparam [2:0] PH_DUMMY = 3'h2;   // one dummy byte
  localparam [2:0] PH_OUT   = 3'h3;   // driving data out
  localparam [2:0] PH_DATA  = 3'h4;   // program data bytes
  localparam [2:0] PH_IGN   = 3'h5;   // rest of frame ignored
  localparam [1:0] OP_CE    = 2'h0;
  localparam [1:0] OP_SE    = 2'h1;
  localparam [1:0] OP_PP    = 2'h2;
  localparam [31:0] PAGE_WRITE_CYCLES = `FEIOC_PAGE_WRITE_CYCLES;

  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------
  // next producer index, wrapping per command
  function [9:0] next_idx;
    input [7:0] op;
    input [9:0] idx;
    begin
      case (op)
        `FEIOC_OP_CODE_READ:   next_idx = {9'h000, ~idx[0]};
        `FEIOC_OP_IDENT_READ:  next_idx = (idx == 10'h002) ? 10'h000 : idx + 10'h001;
        `FEIOC_OP_UNIQUE_READ: next_idx = {6'h00, idx[3:0] + 4'h1};
        default:               next_idx = idx + 10'h001;  // 3ffh wraps to 000h
      endcase
    end
  endfunction

  // identification byte for a given index
  function [7:0] id_byte;
    input [7:0] op;
    input [9:0] idx;
    begin
      case (op)
        `FEIOC_OP_CODE_READ:   id_byte = idx[0] ? DEVICE_CODE : MAKER_CODE;
        `FEIOC_OP_IDENT_READ:  id_byte = (idx[1:0] == 2'h0) ? MAKER_CODE :
                                         (idx[1:0] == 2'h1) ? MEM_TYPE_CODE : CAPACITY_CODE;
        `FEIOC_OP_UNIQUE_READ: id_byte = UNIQUE_ID[8*(15-idx[3:0]) +: 8];
        default:               id_byte = `FEIOC_ERASED_BYTE;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  reg cs_s1, cs_s2, cs_d;        // select, two stages plus edge stage
  reg sclk_s1, sclk_s2, sclk_d;  // serial clock
  reg si_s1, si_s2;              // data in

  // select, clock and data pins pass two flops before any logic looks at them
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
      cs_d    <= 1'b1;
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_d  <= 1'b0;
      si_s1   <= 1'b0;
      si_s2   <= 1'b0;
    end
    else
    begin
      cs_s1   <= spi_cs_n;
      cs_s2   <= cs_s1;
      cs_d    <= cs_s2;
      sclk_s1 <= spi_sclk;
      sclk_s2 <= sclk_s1;
      sclk_d  <= sclk_s2;
      si_s1   <= spi_si;
      si_s2   <= si_s1;
    end
  end

  wire sclk_rise = sclk_s2 & ~sclk_d & ~cs_s2;
  wire sclk_fall = ~sclk_s2 & sclk_d & ~cs_s2;
  wire cs_rise   = cs_s2 & ~cs_d;

  // ----------------------------------------------------------------------
  // frame state
  // ----------------------------------------------------------------------
  reg  [2:0]   phase;             // current frame phase
  reg  [4:0]   bitc;              // bits within phase
  reg  [5:0]   bit_total;         // bits in frame, saturating
  reg  [7:0]   opcode;            // latched opcode
  reg  [7:0]   sh_in;             // input shifter
  reg  [23:0]  addr;              // latched address
  reg  [7:0]   pg_off;            // program offset within page
  reg          got_byte;          // at least one data byte seen
  reg          out_go;            // pulse: start byte producer
  reg  [255:0] pg_vld;            // page buffer byte valid
  reg  [7:0]   pg_buf [0:255];    // page buffer
  reg          busy;              // self-timed cycle running
  wire [7:0]   next_in = {sh_in[6:0], si_s2};

  // opcode decode; a running cycle blocks every command
  wire cmd_has_addr = (next_in == `FEIOC_OP_CODE_READ)   | (next_in == `FEIOC_OP_OTP_ERASE) |
                      (next_in == `FEIOC_OP_OTP_PROGRAM) | (next_in == `FEIOC_OP_OTP_READ) |
                      (next_in == `FEIOC_OP_UNIQUE_READ);

  // shift in on sampled rising sclk edges; select high resets the frame
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase     <= PH_CMD;
      bitc      <= 5'h00;
      bit_total <= 6'h00;
      opcode    <= 8'h00;
      sh_in     <= 8'h00;
      addr      <= 24'h000000;
      pg_off    <= 8'h00;
      got_byte  <= 1'b0;
      out_go    <= 1'b0;
      pg_vld    <= {256{1'b0}};
    end
    else if (cs_s2)
    begin
      phase     <= PH_CMD;        // [R9]
      bitc      <= 5'h00;
      bit_total <= 6'h00;
      got_byte  <= 1'b0;
      out_go    <= 1'b0;
    end
    else
    begin
      out_go <= 1'b0;
      if (sclk_rise)
      begin
        sh_in     <= next_in;
        bit_total <= (bit_total == 6'h3f) ? bit_total : bit_total + 6'h01;
        bitc      <= bitc + 5'h01;
        case (phase)
          PH_CMD:
          begin
            if (bitc == 5'h07)
            begin
              opcode <= next_in;
              bitc   <= 5'h00;
              if (busy)
                phase <= PH_IGN;                          // [R7]
              else if (next_in == `FEIOC_OP_IDENT_READ)
              begin
                phase  <= PH_OUT;                         // [R6]
                out_go <= 1'b1;
              end
              else if (cmd_has_addr)
                phase <= PH_ADDR;
              else
                phase <= PH_IGN;   // single-byte commands act on select rise
              // a refused program must not wipe the buffer a running walk reads
              if ((next_in == `FEIOC_OP_OTP_PROGRAM) & ~busy)
                pg_vld <= {256{1'b0}};                    // [R7]
            end
          end
          PH_ADDR:
          begin
            addr <= {addr[22:0], si_s2};
            if (bitc == 5'h17)
            begin
              bitc   <= 5'h00;
              pg_off <= {addr[6:0], si_s2};
              case (opcode)
                `FEIOC_OP_CODE_READ:
                begin
                  phase  <= PH_OUT;                       // [R5]
                  out_go <= 1'b1;
                end
                `FEIOC_OP_OTP_PROGRAM: phase <= PH_DATA;  // [R16]
                `FEIOC_OP_OTP_ERASE:   phase <= PH_IGN;   // [R12]
                default:               phase <= PH_DUMMY; // [R10] [R18]
              endcase
            end
          end
          PH_DUMMY:
          begin
            if (bitc == 5'h07)
            begin
              bitc   <= 5'h00;
              phase  <= PH_OUT;
              out_go <= 1'b1;
            end
          end
          PH_DATA:
          begin
            if (bitc == 5'h07)
            begin
              bitc             <= 5'h00;
              got_byte         <= 1'b1;
              pg_vld[pg_off]   <= 1'b1;
              pg_off           <= pg_off + 8'h01;   // wraps within the page
            end
          end
          default: bitc <= 5'h00;   // output and ignored phases
        endcase
      end
    end
  end

  // page buffer data; later bytes to the same offset replace earlier ones
  always @(posedge clock)
  begin
    if (sclk_rise & (phase == PH_DATA) & (bitc == 5'h07))
      pg_buf[pg_off] <= next_in;
  end

  // ----------------------------------------------------------------------
  // otp storage and address checks
  // ----------------------------------------------------------------------
  reg  [7:0] otp_mem [0:3071];    // three 1024-byte registers
  wire [3:0] sel    = addr[`FEIOC_SEL_HI:`FEIOC_SEL_LO];
  wire [1:0] sel_m1 = sel[1:0] - 2'h1;
  wire       sel_ok = (addr[23:16] == 8'h00) & (addr[11:10] == 2'h0) &
                      (sel[3:2] == 2'h0) & (sel[1:0] != 2'h0);          // [R14]
  wire lock_hit = ((sel[1:0] == 2'h1) & otp_lock_1) |
                  ((sel[1:0] == 2'h2) & otp_lock_2) |
                  ((sel[1:0] == 2'h3) & otp_lock_3);                    // [R15]
  wire protect_ok = (~protect_bit_2 & ~protect_bit_1 & ~protect_bit_0 & ~protect_complement) |
                    (protect_bit_2 & protect_bit_1 & protect_bit_0 & protect_complement); // [R4]

  // ----------------------------------------------------------------------
  // command execution on select rising
  // ----------------------------------------------------------------------
  wire exec_ok  = cs_rise & ~busy & latch_enabled_flag;   // [R20]
  wire start_ce = exec_ok & (bit_total == `FEIOC_BITS_OPCODE) & protect_ok &
                  ((opcode == `FEIOC_OP_CHIP_ERASE_A) |
                   (opcode == `FEIOC_OP_CHIP_ERASE_B));            // [R1] [R2]
  wire start_se = exec_ok & (opcode == `FEIOC_OP_OTP_ERASE) & sel_ok & ~lock_hit &
                  (bit_total == `FEIOC_BITS_OPCODE_ADDR);          // [R12]
  wire start_pp = exec_ok & (opcode == `FEIOC_OP_OTP_PROGRAM) & sel_ok & ~lock_hit &
                  (phase == PH_DATA) & (bitc == 5'h00) & got_byte; // [R16]
  wire set_wel  = cs_rise & ~busy & (opcode == `FEIOC_OP_WRITE_ENABLE) &
                  (bit_total == `FEIOC_BITS_OPCODE);

  reg  [1:0]  op_kind;            // running cycle kind
  reg  [31:0] timer;              // remaining cycle time
  reg  [10:0] walk;               // storage walk position
  reg  [10:0] walk_len;           // bytes to walk
  reg  [1:0]  tgt_sel;            // target register minus one
  reg  [1:0]  tgt_page;           // target page for program
  wire        walk_en = busy & (walk != walk_len);

  // self-timed cycle: ends when both time and storage walk are done
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy               <= 1'b0;
      in_progress_bit    <= `FEIOC_RST_IN_PROGRESS;
      latch_enabled_flag <= `FEIOC_RST_LATCH_ENABLE;
      op_kind            <= OP_CE;
      timer              <= 32'h00000000;
      walk               <= 11'h000;
      walk_len           <= 11'h000;
      tgt_sel            <= 2'h0;
      tgt_page           <= 2'h0;
    end
    else if (start_ce | start_se | start_pp)
    begin
      busy               <= 1'b1;
      in_progress_bit    <= 1'b1;                 // [R3] [R13] [R16]
      latch_enabled_flag <= 1'b0;                 // cleared before completion
      walk               <= 11'h000;
      tgt_sel            <= sel_m1;
      tgt_page           <= addr[`FEIOC_PAGE_HI:`FEIOC_PAGE_LO];  // [R17]
      if (start_ce)
      begin
        op_kind  <= OP_CE;
        timer    <= ARRAY_ERASE_CYCLES - 32'h1;   // [R3]
        walk_len <= 11'h000;                      // main array is outside this block
      end
      else if (start_se)
      begin
        op_kind  <= OP_SE;
        timer    <= SMALL_ERASE_CYCLES - 32'h1;   // [R13]
        walk_len <= `FEIOC_OTP_BYTES;             // whole register, offset ignored
      end
      else
      begin
        op_kind  <= OP_PP;
        timer    <= PAGE_WRITE_CYCLES - 32'h1;    // [R16]
        walk_len <= `FEIOC_PAGE_BYTES;
      end
    end
    else if (busy)
    begin
      if (timer != 32'h00000000)
        timer <= timer - 32'h1;
      if (walk_en)
        walk <= walk + 11'h001;
      else if (timer == 32'h00000000)
      begin
        busy            <= 1'b0;
        in_progress_bit <= 1'b0;
      end
    end
    else if (set_wel)
      latch_enabled_flag <= 1'b1;
  end

  // storage walk; program can only clear bits, as in real flash cells
  always @(posedge clock)
  begin
    if (walk_en)
    begin
      if (op_kind == OP_SE)
        otp_mem[{tgt_sel, walk[9:0]}] <= `FEIOC_ERASED_BYTE;          // [R11]
      else if ((op_kind == OP_PP) & pg_vld[walk[7:0]])
        otp_mem[{tgt_sel, tgt_page, walk[7:0]}] <=
          otp_mem[{tgt_sel, tgt_page, walk[7:0]}] & pg_buf[walk[7:0]];   // [R11] [R17]
    end
  end

  // ----------------------------------------------------------------------
  // output byte producer into the fifo
  // ----------------------------------------------------------------------
  reg        prod_on;            // producer active this frame
  reg  [9:0] prod_idx;           // byte index / otp offset
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire [7:0] prod_byte = (opcode != `FEIOC_OP_OTP_READ) ? id_byte(opcode, prod_idx) :
                         sel_ok ? otp_mem[{sel_m1, prod_idx}] : `FEIOC_ERASED_BYTE;
  wire       push = prod_on & fifo_in_ready;

  // fills ahead while the fifo has room; stalls when it is full
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prod_on  <= 1'b0;
      prod_idx <= 10'h000;
    end
    else if (cs_s2)
      prod_on <= 1'b0;                                              // [R9]
    else if (out_go)
    begin
      prod_on  <= 1'b1;
      prod_idx <= (opcode == `FEIOC_OP_OTP_READ) ? addr[9:0] : 10'h000;  // [R18]
    end
    else if (push)
      prod_idx <= next_idx(opcode, prod_idx);                       // [R19]
  end

  // ----------------------------------------------------------------------
  // output shifter on sampled falling sclk edges, msb first
  // ----------------------------------------------------------------------
  reg  [7:0] osh;                // output shift register
  reg  [2:0] obit;               // bits left in current byte
  wire       pop = sclk_fall & (phase == PH_OUT) & (obit == 3'h0);

  feioc_fifo #(
    .WIDTH (8),
    .DEPTH (32),
    .AW    (5)
  ) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .flush     (cs_s2),
    .in_valid  (prod_on),
    .in_ready  (fifo_in_ready),
    .in_data   (prod_byte),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  // an empty fifo would give a zero first bit, then stale store bits; the producer stays far ahead in practice
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spi_so    <= `FEIOC_RST_SO;
      spi_so_oe <= `FEIOC_RST_SO_OE;
      osh       <= 8'h00;
      obit      <= 3'h0;
    end
    else
    begin
      spi_so_oe <= ~cs_s2 & (phase == PH_OUT);                     // [R9]
      if (cs_s2)
        obit <= 3'h0;
      else if (pop)
      begin
        spi_so <= fifo_out_valid & fifo_out_data[7];               // [R5] [R6] [R18]
        osh    <= {fifo_out_data[6:0], 1'b0};
        obit   <= 3'h7;
      end
      else if (sclk_fall & (phase == PH_OUT))
      begin
        spi_so <= osh[7];
        osh    <= {osh[6:0], 1'b0};
        obit   <= obit - 3'h1;
      end
    end
  end

endmodule // feioc_top

// *** feioc_defines.vh ***
// constants for the erase, identification and otp command interpreter
//
// Functional notes
// [R1] chip erase is one opcode, 60h or c7h
// [R2] chip erase only with select rising after bit 8
// [R3] chip erase sets busy, clears latch enable
// [R4] chip erase needs all-clear or all-set protection
// [R5] 90h plus zero address returns maker, device code
// [R6] 9fh returns maker, memory type, capacity bytes
// [R7] 9fh not decoded while a cycle runs
// [R8] host avoids 9fh during deep power-down
// [R9] select rising ends id output, back to standby
// [R10] 4bh, address, dummy returns 128-bit unique id
// [R11] three independent 1024-byte otp registers
// [R12] 44h erase needs latch enable, exact 32 bits
// [R13] otp erase is timed, busy set, enable cleared
// [R14] address bits 15:12 pick register one to three
// [R15] locked otp register ignores erase and program
// [R16] 42h program needs data byte, timed cycle
// [R17] each otp register holds four program pages
// [R18] 48h, address, dummy, data on falling edges
// [R19] otp read offset wraps 3ffh to 000h
// [R20] no latch enable means erase, program ignored
`ifndef FEIOC_DEFINES_VH
`define FEIOC_DEFINES_VH

// ----------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------
`define FEIOC_OP_WRITE_ENABLE   8'h06
`define FEIOC_OP_CHIP_ERASE_A   8'h60
`define FEIOC_OP_CHIP_ERASE_B   8'hc7
`define FEIOC_OP_CODE_READ      8'h90
`define FEIOC_OP_IDENT_READ     8'h9f
`define FEIOC_OP_UNIQUE_READ    8'h4b
`define FEIOC_OP_OTP_ERASE      8'h44
`define FEIOC_OP_OTP_PROGRAM    8'h42
`define FEIOC_OP_OTP_READ       8'h48

// ----------------------------------------------------------------------
// frame bit counts and otp address fields
// ----------------------------------------------------------------------
`define FEIOC_BITS_OPCODE       6'h08
`define FEIOC_BITS_OPCODE_ADDR  6'h20
`define FEIOC_SEL_HI            15
`define FEIOC_SEL_LO            12
`define FEIOC_PAGE_HI           9
`define FEIOC_PAGE_LO           8
`define FEIOC_OTP_BYTES         11'h400
`define FEIOC_PAGE_BYTES        11'h100
`define FEIOC_ERASED_BYTE       8'hff

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define FEIOC_RST_SO            1'b0
`define FEIOC_RST_SO_OE         1'b0
`define FEIOC_RST_LATCH_ENABLE  1'b0
`define FEIOC_RST_IN_PROGRESS   1'b0

// ----------------------------------------------------------------------
// timing: times as given, cycles derived (least times round up)
// ----------------------------------------------------------------------
`define FEIOC_CLK_PERIOD_NS         10
`define FEIOC_ARRAY_ERASE_TIME_US   20000
`define FEIOC_SMALL_ERASE_TIME_US   50
`define FEIOC_PAGE_WRITE_TIME_US    3
`define FEIOC_MAX_READ_CLOCK_MHZ    20
`define FEIOC_ARRAY_ERASE_CYCLES \
  ((`FEIOC_ARRAY_ERASE_TIME_US * 1000 + `FEIOC_CLK_PERIOD_NS - 1) / `FEIOC_CLK_PERIOD_NS)
`define FEIOC_SMALL_ERASE_CYCLES \
  ((`FEIOC_SMALL_ERASE_TIME_US * 1000 + `FEIOC_CLK_PERIOD_NS - 1) / `FEIOC_CLK_PERIOD_NS)
`define FEIOC_PAGE_WRITE_CYCLES \
  ((`FEIOC_PAGE_WRITE_TIME_US * 1000 + `FEIOC_CLK_PERIOD_NS - 1) / `FEIOC_CLK_PERIOD_NS)

`endif

// *** feioc_fifo.v ***
// byte fifo between the output byte producer and the serial shifter
`timescale 1ns/100ps
module feioc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clock,
  input  wire             rst_n,
  input  wire             flush,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  // ----------------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------------
  reg [WIDTH-1:0] mem [0:DEPTH-1];   // word store
  reg [AW-1:0]    wr_ptr;            // next write slot
  reg [AW-1:0]    rd_ptr;            // next read slot
  reg [AW:0]      fill;              // words held

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (fill != DEPTH[AW:0]);   // honest full
  assign out_valid = (fill != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];

  // pointer and fill bookkeeping; flush wins so a new frame starts empty
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      fill   <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      fill   <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      if (push & ~pop)
        fill <= fill + {{AW{1'b0}}, 1'b1};
      else if (pop & ~push)
        fill <= fill - {{AW{1'b0}}, 1'b1};
    end
  end

  // data write, no reset needed on the store
  always @(posedge clock)
  begin
    if (push & ~flush)
      mem[wr_ptr] <= in_data;
  end

endmodule // feioc_fifo

// *** feioc_chk_sva.sv ***
// port checker for the flash command interpreter
`timescale 1ns/100ps
module feioc_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_so,
  input wire logic spi_so_oe,
  input wire logic latch_enabled_flag,
  input wire logic in_progress_bit
);
  // --------
  // properties, one clock domain
  // --------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  oe_idle_off_a: assert property (spi_cs_n [*6] |-> !spi_so_oe)
    else $error("oe while idle");
  busy_no_out_a: assert property (in_progress_bit |-> !spi_so_oe)
    else $error("output while busy");
  start_needs_flag_a: assert property ($rose(in_progress_bit) |-> $past(latch_enabled_flag))
    else $error("start without enable");
  start_clears_flag_a: assert property ($rose(in_progress_bit) |-> !latch_enabled_flag)
    else $error("enable kept at start");
  start_on_cs_a: assert property ($rose(in_progress_bit) |-> $past(spi_cs_n, 3))
    else $error("start while selected");
  busy_min_a: assert property ($rose(in_progress_bit) |=> in_progress_bit [*8])
    else $error("cycle too short");
  flag_held_a: assert property (in_progress_bit && $past(in_progress_bit) |-> $stable(latch_enabled_flag))
    else $error("enable moved while busy");
  so_on_fall_a: assert property ($changed(spi_so) |-> !$past(spi_sclk, 2))
    else $error("output not after fall");
  oe_on_sel_a: assert property ($rose(spi_so_oe) |-> !spi_cs_n)
    else $error("oe while deselected");
  cover property ($rose(in_progress_bit));
  cover property ($rose(spi_so_oe));
  cover property ($rose(latch_enabled_flag));
endmodule // feioc_chk

bind feioc_top feioc_chk u_chk (.clock, .rst_n, .spi_cs_n, .spi_sclk, .spi_so, .spi_so_oe,
  .latch_enabled_flag, .in_progress_bit);

// *** feioc_host.sv ***
// serial host model driving select, clock and data
`timescale 1ns/100ps
module feioc_host (
  output logic cs_n,
  output logic sclk,
  output logic si,
  input  wire  so
);
  // idle: deselected, clock low, never in deep power-down here
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end
  // one frame: nb bits out msb first, nr bits in on rising edges
  task automatic frame(input int nb, input logic [63:0] tx, input int nr, output logic [31:0] rx);
    int i;
    rx = 32'h0;
    cs_n = 1'b0;
    #40;
    for (i = 0; i < nb + nr; i++)
    begin
      si = (i < nb) ? tx[nb-1-i] : ~si; // toggles after use, no stale level
      #40 sclk = 1'b1;
      if (i >= nb) rx = {rx[30:0], so};
      #40 sclk = 1'b0;
    end
    #40 cs_n = 1'b1; // rises only after a whole last bit
    #200;
  endtask
endmodule // feioc_host

// *** tb.sv ***
// self-checking bench for the flash command interpreter
`timescale 1ns/100ps
module tb;
  logic        clock;
  logic        rst_n;
  logic [3:0]  prot;         // protect bits 2..0, complement
  logic [2:0]  lock;         // otp locks 3..1
  logic [31:0] r;            // last read
  int          miscompares = 0;
  int          n_checks = 0;
  int          cycles = 0;
  wire         spi_cs_n, spi_sclk, spi_si, spi_so, spi_so_oe, latch_enabled_flag, in_progress_bit;
  wire         so_pin = spi_so_oe ? spi_so : 1'b1; // released line pulled up
  feioc_top #(.ARRAY_ERASE_CYCLES(32'd200), .SMALL_ERASE_CYCLES(32'd100)) dut (
    .clock, .rst_n, .spi_cs_n, .spi_sclk, .spi_si, .spi_so, .spi_so_oe,
    .protect_bit_2(prot[3]), .protect_bit_1(prot[2]), .protect_bit_0(prot[1]),
    .protect_complement(prot[0]), .otp_lock_1(lock[0]), .otp_lock_2(lock[1]),
    .otp_lock_3(lock[2]), .latch_enabled_flag, .in_progress_bit);
  feioc_host host (.cs_n(spi_cs_n), .sclk(spi_sclk), .si(spi_si), .so(so_pin));
  // --------
  // helpers
  // --------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic fr(input int nb, input logic [63:0] tx, input int nr = 0);
    host.frame(nb, tx, nr, r);
  endtask
  // bounded wait for the self-timed cycle
  task automatic wait_idle();
    for (int k = 0; k < 3000 && in_progress_bit !== 1'b0; k++) @(negedge clock);
  endtask
  task automatic summarize();
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // hang guard, far above the expected run
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      summarize();
    end
  end
  // --------
  // main sequence
  // --------
  initial
  begin
    rst_n = 1'b0;
    prot = 4'h0;
    lock = 3'h0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    chk(latch_enabled_flag, 0);
    fr(8, 64'h60);
    chk(in_progress_bit, 0);
    fr(8, 64'h9f, 24);
    chk(r, 32'h5a6315);
    fr(32, 64'h90000000, 16);
    chk(r, 32'h5a14);
    fr(40, 64'h4b00000000, 32);
    chk(r, 32'h01234567);
    fr(8, 64'h06);
    fr(9, 64'hc0);
    chk(in_progress_bit, 0);
    prot = 4'h2;
    fr(8, 64'hc7);
    chk(in_progress_bit, 0);
    prot = 4'hf;
    fr(8, 64'hc7);
    chk({in_progress_bit, latch_enabled_flag}, 2'b10);
    fr(8, 64'h9f, 8);
    chk({in_progress_bit, r[7:0]}, 32'h1ff);
    wait_idle();
    fr(8, 64'h06);
    fr(32, 64'h44001000);
    chk(in_progress_bit, 1);
    wait_idle();
    fr(8, 64'h06);
    fr(40, 64'h420013ffa5);
    wait_idle();
    fr(40, 64'h480013ff00, 16);
    chk(r, 32'ha5ff);
    lock = 3'h1;
    fr(8, 64'h06);
    fr(32, 64'h44004000);
    chk(in_progress_bit, 0);
    fr(32, 64'h44001000);
    chk({in_progress_bit, latch_enabled_flag}, 2'b01);
    summarize();
  end
endmodule // tb
